// ===== core/mrc_reset_ctrl.sv
`timescale 1ns/100ps

// Notes on behaviour
// R1 - Any reset halts the core, loads register defaults, disables interrupts and timers.
// R2 - RAM is kept during reset; only the stack pointer returns to default.
// R3 - Port latches go to 0xff open-drain; weak pull-ups stay enabled.
// R4 - A supply monitor reset drives the reset pin low while held.
// R5 - On release the program counter clears and the internal oscillator is selected.
// R6 - On release the watchdog runs, clocked by system clock divided by 12.
// R7 - Fetch after release always starts at address 0x0000.
// R8 - During power-up the reset pin is driven low until above the threshold.
// R9 - Release waits 3, 7 or 15 ms by supply level; slow ramp shortens it.
// R10 - Leaving a power-on reset sets the power-on flag, bit 1 of the cause register; not set if another source still holds reset when the delay ends.
// R11 - Every other reset clears the power-on flag.
// R12 - Software reads the power-on flag and treats RAM as undefined after power-up.
// R13 - All sources merge into one synchronous reset held until the last condition clears.
module mrc_reset_ctrl
  import mrc_pkg::*;
#(
  parameter int POR_CYC_LO_P = POR_CYC_LO,
  parameter int POR_CYC_MD_P = POR_CYC_MD,
  parameter int POR_CYC_HI_P = POR_CYC_HI
) (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // Supply monitors
  input  wire logic        por_below_i,
  input  wire logic [1:0]  vbat_level_i,
  input  wire logic        slow_ramp_i,
  input  wire logic        vdd_fail_i,
  // Reset pin
  input  wire logic        rst_pin_i,
  output logic             rst_pin_o,
  output logic             rst_pin_oe_o,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Core and peripheral control
  output logic             sys_rst_o,
  output logic             core_halt_o,
  output logic             sfr_init_o,
  output logic             irq_off_o,
  output logic             timer_off_o,
  output logic             sp_reset_o,
  output logic             ram_wr_block_o,
  output logic [7:0]       port_latch_o,
  output logic             port_od_o,
  output logic             weak_pullup_o,
  output logic [15:0]      pc_o,
  output logic             pc_load_o,
  output logic             clk_int_sel_o,
  output logic             wdt_en_o,
  output logic             wdt_tick_o
);

  // ****************************************************************
  // Reset release
  // ****************************************************************

  logic             rst_meta_r;
  logic             rst_n;
  mrc_state_t       state_r;
  mrc_state_t       state_nxt;
  logic [DLY_W-1:0] cnt_r;
  logic [DLY_W-1:0] dly_lim_r;
  logic [DLY_W-1:0] dly_sel;
  logic             ext_rst;
  logic             sw_rst_r;
  logic             other_src;
  logic             pin_drive_r;
  logic [4:0]       cause_r;
  logic [1:0]       ctrl_r;
  logic [3:0]       div_cnt_r;
  logic             ack_r;
  logic             req;
  logic             wr_acc;
  logic             dly_done;

  // Two-stage release of the external reset
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // ****************************************************************
  // Reset sources
  // ****************************************************************

  // Pin is only an input while this block does not drive it
  assign ext_rst   = !rst_pin_i && !pin_drive_r;
  // R13 merge sources
  assign other_src = ext_rst || vdd_fail_i || sw_rst_r;

  // R9 delay by supply level, halved for a slow ramp
  always_comb begin
    if (vbat_level_i == VBAT_LOW) begin
      dly_sel = DLY_W'(POR_CYC_LO_P);
    end else if (vbat_level_i == VBAT_MID) begin
      dly_sel = DLY_W'(POR_CYC_MD_P);
    end else begin
      dly_sel = DLY_W'(POR_CYC_HI_P);
    end
    if (slow_ramp_i) begin
      dly_sel = dly_sel >> 1;
    end
  end

  assign dly_done = (cnt_r >= dly_lim_r - DLY_W'(1));

  // ****************************************************************
  // Sequencer
  // ****************************************************************

  // R13 next state, slowest release wins
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_POWER_UP: begin
        if (!por_below_i) state_nxt = ST_POR_DELAY;
      end
      ST_POR_DELAY: begin
        if (por_below_i) state_nxt = ST_POWER_UP;
        else if (dly_done) state_nxt = other_src ? ST_HELD : ST_RUN;
      end
      ST_HELD: begin
        if (por_below_i) state_nxt = ST_POWER_UP;
        else if (!other_src && !pin_drive_r) state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (por_below_i) state_nxt = ST_POWER_UP;
        else if (other_src) state_nxt = ST_HELD;
      end
    endcase
  end

  // State register
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_POWER_UP;
    end else begin
      state_r <= state_nxt;
    end
  end

  // R9 release delay counter
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r     <= '0;
      dly_lim_r <= '0;
    end else if (state_r == ST_POWER_UP) begin
      cnt_r     <= '0;
      dly_lim_r <= dly_sel;
    end else if (state_r == ST_POR_DELAY && !dly_done) begin
      cnt_r <= cnt_r + DLY_W'(1);
    end
  end

  // R4 R8 drive the pin low on power-up or supply failure
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_drive_r <= 1'b1;
    end else begin
      pin_drive_r <= (state_nxt == ST_POWER_UP) ||
                     (state_nxt != ST_RUN && vdd_fail_i);
    end
  end

  assign rst_pin_o    = 1'b0;
  assign rst_pin_oe_o = pin_drive_r;

  // ****************************************************************
  // Reset outputs
  // ****************************************************************

  // R1 R2 R3 R5 R7 hold defaults while in reset
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      sys_rst_o    <= 1'b1;
      port_latch_o <= PORT_LATCH_RST;
      pc_o         <= FETCH_START;
      pc_load_o    <= 1'b0;
    end else begin
      sys_rst_o <= (state_nxt != ST_RUN);
      pc_load_o <= (state_nxt == ST_RUN) && (state_r != ST_RUN);
      if (state_nxt != ST_RUN) begin
        port_latch_o <= PORT_LATCH_RST;
        pc_o         <= FETCH_START;
      end
    end
  end

  assign core_halt_o    = sys_rst_o;
  assign sfr_init_o     = sys_rst_o;
  assign irq_off_o      = sys_rst_o;
  assign timer_off_o    = sys_rst_o;
  assign sp_reset_o     = sys_rst_o;
  // R2 RAM writes blocked, contents kept
  assign ram_wr_block_o = sys_rst_o;
  assign port_od_o      = sys_rst_o;
  assign weak_pullup_o  = 1'b1;
  assign clk_int_sel_o  = !ctrl_r[CTRL_EXT_BIT];
  assign wdt_en_o       = ctrl_r[CTRL_WDT_BIT] && !sys_rst_o;

  // ****************************************************************
  // Watchdog clock
  // ****************************************************************

  // R6 divide system clock by twelve
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_r  <= '0;
      wdt_tick_o <= 1'b0;
    end else if (!wdt_en_o) begin
      div_cnt_r  <= '0;
      wdt_tick_o <= 1'b0;
    end else begin
      wdt_tick_o <= (div_cnt_r == WDT_DIV_LAST);
      div_cnt_r  <= (div_cnt_r == WDT_DIV_LAST) ? '0 : div_cnt_r + 4'h1;
    end
  end

  // ****************************************************************
  // Register slave
  // ****************************************************************

  assign req               = avs_read_i || avs_write_i;
  assign avs_waitrequest_o = req && !ack_r;
  assign wr_acc            = avs_write_i && ack_r;

  // One wait state, read data captured with it
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ack_r          <= 1'b0;
      avs_readdata_o <= '0;
    end else begin
      ack_r <= req && !ack_r;
      if (avs_read_i && !ack_r) begin
        unique case (avs_address_i)
          ADDR_CAUSE: avs_readdata_o <= {27'h0, cause_r};
          ADDR_CTRL:  avs_readdata_o <= {30'h0, ctrl_r};
          ADDR_STAT:  avs_readdata_o <= {30'h0, state_r};
          default:    avs_readdata_o <= '0;
        endcase
      end
    end
  end

  // Software reset request
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      sw_rst_r <= 1'b0;
    end else if (state_r == ST_HELD) begin
      sw_rst_r <= 1'b0;
    end else if (wr_acc && avs_address_i == ADDR_CAUSE && avs_byteenable_i[0]) begin
      sw_rst_r <= avs_writedata_i[CAUSE_SW_BIT];
    end
  end

  // R5 R6 control back to defaults in reset
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RST;
    end else if (state_r != ST_RUN) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_acc && avs_address_i == ADDR_CTRL && avs_byteenable_i[0]) begin
      ctrl_r <= avs_writedata_i[1:0];
    end
  end

  // R10 R11 reset cause capture
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      cause_r <= CAUSE_RST;
    end else if (state_r == ST_POR_DELAY && state_nxt == ST_RUN) begin
      cause_r <= 5'h0 | (5'h1 << CAUSE_POR_BIT);
    end else if (state_nxt == ST_HELD && state_r != ST_HELD) begin
      cause_r <= {sw_rst_r, vdd_fail_i, 2'b00, ext_rst};
    end else if (state_r == ST_HELD) begin
      cause_r <= cause_r | {sw_rst_r, vdd_fail_i, 2'b00, ext_rst};
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n);

  a_halt_in_reset: assert property ( // R1
    other_src |=> core_halt_o && sfr_init_o && irq_off_o && timer_off_o)
    else $error("core not halted during reset");

  a_ram_kept: assert property ( // R2
    $rose(sys_rst_o) |-> ram_wr_block_o && sp_reset_o)
    else $error("RAM not protected in reset");

  a_port_default: assert property ( // R3
    sys_rst_o |-> port_latch_o == PORT_LATCH_RST && port_od_o && weak_pullup_o)
    else $error("port default wrong in reset");

  a_pin_vdd_low: assert property ( // R4
    (state_r != ST_POWER_UP && vdd_fail_i) |=> rst_pin_oe_o && !rst_pin_o)
    else $error("pin not driven on supply fail");

  a_clk_default: assert property ( // R5
    $fell(sys_rst_o) |-> clk_int_sel_o && pc_load_o)
    else $error("clock default wrong at release");

  a_wdt_start: assert property ( // R6
    $fell(sys_rst_o) |-> wdt_en_o ##1 !wdt_tick_o [*8])
    else $error("watchdog not started at release");

  a_wdt_period: assert property ( // R6
    wdt_tick_o |-> $past(div_cnt_r) == WDT_DIV_LAST)
    else $error("watchdog tick off divide");

  a_fetch_zero: assert property ( // R7
    pc_load_o |-> pc_o == FETCH_START)
    else $error("fetch address not zero");

  a_pin_por_low: assert property ( // R8
    (state_r == ST_POWER_UP && por_below_i) |=> rst_pin_oe_o)
    else $error("pin not driven in power-up");

  a_por_delay: assert property ( // R9
    (state_r == ST_POR_DELAY && !dly_done) |=> sys_rst_o)
    else $error("released before delay end");

  a_por_flag: assert property ( // R10
    (state_r == ST_POR_DELAY && state_nxt == ST_RUN) |=> cause_r[CAUSE_POR_BIT])
    else $error("power-on flag not set");

  a_por_clear: assert property ( // R11
    (state_r == ST_HELD && state_nxt == ST_RUN) |=> !cause_r[CAUSE_POR_BIT])
    else $error("power-on flag not cleared");

  a_merge_hold: assert property ( // R13
    (other_src && state_r == ST_RUN) |=> sys_rst_o ##1 sys_rst_o)
    else $error("merged reset not held");

  c_power_up: cover property (state_r == ST_POR_DELAY ##1 state_r == ST_RUN);
  c_vdd_fail: cover property (state_r == ST_RUN && vdd_fail_i);
  c_sw_reset: cover property (state_r == ST_RUN && sw_rst_r);
  c_pin_reset: cover property (state_r == ST_RUN && ext_rst);

endmodule : mrc_reset_ctrl

// ===== core/mrc_pkg.sv
// ****************************************************************
// Reset controller constants
// ****************************************************************
package mrc_pkg;

  // Clock rate and power-on release delays
  localparam int CLK_KHZ       = 10000;
  localparam int POR_DLY_LO_US = 3000;
  localparam int POR_DLY_MD_US = 7000;
  localparam int POR_DLY_HI_US = 15000;
  localparam int POR_CYC_LO    = POR_DLY_LO_US * (CLK_KHZ / 1000);
  localparam int POR_CYC_MD    = POR_DLY_MD_US * (CLK_KHZ / 1000);
  localparam int POR_CYC_HI    = POR_DLY_HI_US * (CLK_KHZ / 1000);
  localparam int DLY_W         = 20;

  // Supply level codes on vbat_level_i
  localparam logic [1:0] VBAT_LOW = 2'h0;
  localparam logic [1:0] VBAT_MID = 2'h1;

  // Watchdog clock divider
  localparam int         WDT_DIV      = 12;
  localparam logic [3:0] WDT_DIV_LAST = 4'(WDT_DIV - 1);

  // Register byte addresses
  localparam logic [3:0] ADDR_CAUSE = 4'h0;
  localparam logic [3:0] ADDR_CTRL  = 4'h4;
  localparam logic [3:0] ADDR_STAT  = 4'h8;

  // Field positions
  localparam int CAUSE_PIN_BIT = 0;
  localparam int CAUSE_POR_BIT = 1;
  localparam int CAUSE_VDD_BIT = 3;
  localparam int CAUSE_SW_BIT  = 4;
  localparam int CTRL_WDT_BIT  = 0;
  localparam int CTRL_EXT_BIT  = 1;

  // Values after reset
  localparam logic [7:0]  PORT_LATCH_RST = 8'hff;
  localparam logic [15:0] FETCH_START    = 16'h0000;
  localparam logic [1:0]  CTRL_RST       = 2'h1;
  localparam logic [4:0]  CAUSE_RST      = 5'h00;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_POWER_UP,
    ST_POR_DELAY,
    ST_HELD,
    ST_RUN
  } mrc_state_t;

endpackage : mrc_pkg

// ===== test/mrc_core_model.sv
`timescale 1ns/100ps

// ****************************************************************
// Core model held in reset
// ****************************************************************
module mrc_core_model #(
  parameter logic [7:0] SP_RST = 8'h07
) (
  // Clock and controls from the block
  input  wire logic        clock_i,
  input  wire logic        sp_reset_i,
  input  wire logic        core_halt_i,
  input  wire logic        pc_load_i,
  input  wire logic [15:0] pc_i,
  // Observed core state
  output logic [15:0]      fetch_o,
  output logic [7:0]       sp_o
);
  always_ff @(posedge clock_i) begin
    if (pc_load_i) begin
      fetch_o <= pc_i;
    end else if (!core_halt_i) begin
      fetch_o <= fetch_o + 16'h0001;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sp_reset_i) begin
      sp_o <= SP_RST;
    end else begin
      sp_o <= sp_o + 8'h01;
    end
  end
endmodule : mrc_core_model

// ===== test/tb_top.sv
`timescale 1ns/100ps

// ****************************************************************
// Reset controller bench
// ****************************************************************
module tb_top
  import mrc_pkg::*;
;
  localparam int LO = 20;
  localparam int MD = 40;
  localparam int HI = 60;
  logic clock_i = 1'b0;
  logic rst_n_i, por_below_i, slow_ramp_i, vdd_fail_i, ext_low, avs_read_i, avs_write_i;
  logic [1:0] vbat_level_i;
  logic [3:0] avs_address_i, avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  logic rst_pin_i, rst_pin_o, rst_pin_oe_o, avs_waitrequest_o, sys_rst_o, core_halt_o;
  logic sfr_init_o, irq_off_o, timer_off_o, sp_reset_o, ram_wr_block_o, port_od_o;
  logic weak_pullup_o, pc_load_o, clk_int_sel_o, wdt_en_o, wdt_tick_o;
  logic [7:0] port_latch_o, sp;
  logic [15:0] pc_o, fetch;
  int n_fail = 0;
  int n_checks = 0;

  // Clock and pulled-up reset pin
  always #50 clock_i = !clock_i;
  assign rst_pin_i = rst_pin_oe_o ? rst_pin_o : !ext_low;

  mrc_reset_ctrl #(.POR_CYC_LO_P(LO), .POR_CYC_MD_P(MD), .POR_CYC_HI_P(HI)) mrc_reset_ctrl_i (
    .clock_i, .rst_n_i, .por_below_i, .vbat_level_i, .slow_ramp_i, .vdd_fail_i, .rst_pin_i,
    .rst_pin_o, .rst_pin_oe_o, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .sys_rst_o, .core_halt_o,
    .sfr_init_o, .irq_off_o, .timer_off_o, .sp_reset_o, .ram_wr_block_o, .port_latch_o,
    .port_od_o, .weak_pullup_o, .pc_o, .pc_load_o, .clk_int_sel_o, .wdt_en_o, .wdt_tick_o);

  mrc_core_model mrc_core_model_i (.clock_i, .sp_reset_i(sp_reset_o),
    .core_halt_i(core_halt_o), .pc_load_i(pc_load_o), .pc_i(pc_o), .fetch_o(fetch), .sp_o(sp));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One bus transfer, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    avs_read_i      <= !wr;
    avs_write_i     <= wr;
    avs_address_i   <= a;
    avs_writedata_i <= d;
    do begin
      @(posedge clock_i);
    end while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus

  // Bounded wait for the merged reset to reach a level
  task automatic wait_rst(input logic lvl);
    for (int k = 0; k < 8 && sys_rst_o !== lvl; k++) @(negedge clock_i);
  endtask : wait_rst

  task automatic t_por(input logic [1:0] lv, input logic sr, input int lim);
    @(posedge clock_i);
    por_below_i  <= 1'b1;
    vbat_level_i <= lv;
    slow_ramp_i  <= sr;
    repeat (4) @(negedge clock_i);
    chk("pin_oe", rst_pin_oe_o, 1);
    chk("group", {sys_rst_o, core_halt_o, sfr_init_o, irq_off_o, timer_off_o}, 5'h1f);
    chk("ram_sp", {sp_reset_o, ram_wr_block_o}, 2'h3);
    chk("port", {port_od_o, weak_pullup_o, port_latch_o}, 10'h3ff);
    @(posedge clock_i);
    por_below_i <= 1'b0;
    repeat (lim + 1) @(negedge clock_i);
    chk("held", {sys_rst_o, rst_pin_oe_o}, 2'h2);
    @(negedge clock_i);
    chk("release", sys_rst_o, 0);
    chk("pc", {pc_load_o, pc_o}, 17'h10000);
    chk("clk_wdt", {clk_int_sel_o, wdt_en_o, weak_pullup_o, sp}, 11'h707);
    @(negedge clock_i);
    chk("fetch", fetch, 16'h0000);
    bus(1'b0, ADDR_CAUSE, 32'h0);
    chk("cause", rd, 32'h2);
    $display("test por level %0d slow %0d done", lv, sr);
  endtask : t_por

  task automatic t_wdt();
    int n;
    for (n = 0; n < 30 && wdt_tick_o !== 1'b1; n++) @(negedge clock_i);
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
    end while (wdt_tick_o !== 1'b1 && n < 30);
    chk("wdt_period", n, WDT_DIV);
    $display("test watchdog done");
  endtask : t_wdt

  task automatic t_vdd();
    @(posedge clock_i);
    vdd_fail_i <= 1'b1;
    ext_low    <= 1'b1;
    repeat (3) @(negedge clock_i);
    chk("vdd_pin", {sys_rst_o, irq_off_o, rst_pin_oe_o, rst_pin_o}, 4'he);
    @(posedge clock_i);
    vdd_fail_i <= 1'b0;
    repeat (4) @(negedge clock_i);
    chk("pin_holds", {sys_rst_o, rst_pin_oe_o}, 2'h2);
    @(posedge clock_i);
    ext_low <= 1'b0;
    wait_rst(1'b0);
    chk("vdd_rel", sys_rst_o, 0);
    bus(1'b0, ADDR_CAUSE, 32'h0);
    chk("cause", rd, 32'h9);
    $display("test supply fail done");
  endtask : t_vdd

  task automatic t_regs();
    bus(1'b0, 4'hc, 32'h0);
    chk("unmapped", rd, 0);
    bus(1'b1, ADDR_CTRL, 32'h0);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", rd, 0);
    chk("wdt_off", {wdt_en_o, clk_int_sel_o}, 2'h1);
    bus(1'b1, ADDR_CAUSE, 32'h10);
    wait_rst(1'b1);
    chk("sw_rst", sys_rst_o, 1);
    wait_rst(1'b0);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl_dflt", {rd[30:0], wdt_en_o}, 32'h3);
    bus(1'b0, ADDR_CAUSE, 32'h0);
    chk("por_clr", rd[CAUSE_POR_BIT], 0);
    $display("test registers done");
  endtask : t_regs

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    {por_below_i, slow_ramp_i, vdd_fail_i, ext_low, avs_read_i, avs_write_i} = 6'h20;
    vbat_level_i = 2'h0;
    avs_address_i = 4'h0;
    avs_byteenable_i = 4'h1;
    avs_writedata_i = 32'h0;
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    t_por(VBAT_LOW, 1'b0, LO);
    t_por(VBAT_MID, 1'b0, MD);
    t_por(2'h2, 1'b0, HI);
    t_por(2'h3, 1'b1, HI / 2);
    t_wdt();
    t_vdd();
    t_regs();
    tally_and_finish();
  end

  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge clock_i);
    n_fail++;
    tally_and_finish();
  end
endmodule : tb_top
